// *** hdl/pcs_pkg.sv ***
package pcs_pkg;
  // Startup clock choice
  typedef enum logic [0:0] {PCS_CLK_CONFIG, PCS_CLK_USER} pcs_clk_sel_t;
  // Length count alignment method
  typedef enum logic [0:0] {PCS_ALIGN_LENGTH, PCS_ALIGN_DONE} pcs_align_t;
  // Event codes shared by all three selections
  typedef enum logic [3:0] {
    PCS_EV_C1 = 4'h0,
    PCS_EV_C2 = 4'h1,
    PCS_EV_C3 = 4'h2,
    PCS_EV_C4 = 4'h3,
    PCS_EV_U2 = 4'h4,
    PCS_EV_U3 = 4'h5,
    PCS_EV_U4 = 4'h6,
    PCS_EV_DI = 4'h7,
    PCS_EV_DI1 = 4'h8,
    PCS_EV_DI2 = 4'h9
  } pcs_event_t;
  localparam pcs_event_t PCS_DONE_DEFAULT = PCS_EV_C1;
  localparam pcs_event_t PCS_GSR_DEFAULT = PCS_EV_C3;
  localparam pcs_event_t PCS_IO_DEFAULT = PCS_EV_C2;
  localparam logic [2:0] PCS_CNT_W_MAX = 3'h4;
  localparam logic [1:0] PCS_DI_MAX = 2'h2;
  localparam int PCS_CFG_DIV = 4;
  localparam logic [1:0] PCS_CFG_DIV_LAST = 2'(PCS_CFG_DIV - 1);
endpackage : pcs_pkg

// *** hdl/pcs_sel_if.sv ***
`timescale 1ns/10ps
interface pcs_sel_if;
  import pcs_pkg::*;
  pcs_clk_sel_t clk_sel;
  logic sync;
  pcs_event_t done_ev;
  pcs_event_t gsr_ev;
  pcs_event_t io_ev;
  logic done_ok;
  logic gsr_ok;
  logic io_ok;
  modport checker_mp (input clk_sel, sync, done_ev, gsr_ev, io_ev,
    output done_ok, gsr_ok, io_ok);
  modport top_mp (output clk_sel, sync, done_ev, gsr_ev, io_ev,
    input done_ok, gsr_ok, io_ok);
endinterface : pcs_sel_if

// *** hdl/pcs_sel_check.sv ***
`timescale 1ns/10ps
module pcs_sel_check
(
  pcs_sel_if.checker_mp sel
);
  import pcs_pkg::*;
  // Allowed completion choices
  function automatic logic pcs_done_valid(input pcs_clk_sel_t c, input logic s,
    input pcs_event_t e);
    logic r;
    r = 1'b0;
    if (c == PCS_CLK_CONFIG)
      r = s ? (e <= PCS_EV_C3) : (e <= PCS_EV_C4);
    else
      r = s ? (e == PCS_EV_C1 || e == PCS_EV_U2)
            : (e == PCS_EV_C1 || (e >= PCS_EV_U2 && e <= PCS_EV_U4));
    return r;
  endfunction : pcs_done_valid
  // Allowed release choices, shared by reset and I/O release
  function automatic logic pcs_rel_valid(input pcs_clk_sel_t c, input logic s,
    input pcs_event_t e);
    logic r;
    r = 1'b0;
    if (c == PCS_CLK_CONFIG)
      r = s ? (e == PCS_EV_C2 || e == PCS_EV_C3 || e == PCS_EV_DI || e == PCS_EV_DI1)
            : (e >= PCS_EV_C2 && e <= PCS_EV_C4);
    else
      r = s ? (e == PCS_EV_U2 || (e >= PCS_EV_DI && e <= PCS_EV_DI2))
            : (e >= PCS_EV_U2 && e <= PCS_EV_U4);
    return r;
  endfunction : pcs_rel_valid
  assign sel.done_ok = pcs_done_valid(sel.clk_sel, sel.sync, sel.done_ev);
  assign sel.gsr_ok = pcs_rel_valid(sel.clk_sel, sel.sync, sel.gsr_ev);
  assign sel.io_ok = pcs_rel_valid(sel.clk_sel, sel.sync, sel.io_ev);
endmodule : pcs_sel_check

// *** hdl/pcs_startup_seq.sv ***
`timescale 1ns/10ps
module pcs_startup_seq
(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // Configuration progress
  input wire logic [23:0] length_count_target_in,
  input wire logic config_bit_strobe_in,
  input wire logic cclk_is_output_in,
  input wire logic cclk_pin_in,
  input wire pcs_pkg::pcs_align_t length_count_alignment_in,
  // Startup selections
  input wire pcs_pkg::pcs_clk_sel_t startup_clock_select_in,
  input wire logic sync_to_done_input_in,
  input wire pcs_pkg::pcs_event_t completion_assert_event_in,
  input wire pcs_pkg::pcs_event_t global_reset_release_event_in,
  input wire pcs_pkg::pcs_event_t io_release_event_in,
  // Startup clocks and done line
  input wire logic user_clk_in,
  input wire logic done_input_signal_in,
  // Outputs
  output logic cclk_pin_out,
  output logic cclk_pin_oe_out,
  output logic completion_out,
  output logic global_set_reset_out,
  output logic io_tristate_out,
  output logic selection_error_out,
  output logic startup_finished_out
);
  import pcs_pkg::*;

  typedef enum logic [1:0] {PCS_ST_LOAD, PCS_ST_RUN, PCS_ST_END} pcs_state_t;

  pcs_sel_if sel ();
  pcs_state_t state_reg, state_next;
  logic [23:0] bits_reg;
  logic [1:0] osc_reg;
  logic cclk_reg;
  logic cclk_prev_reg, user_s1_reg, user_s2_reg, user_prev_reg;
  logic di_s1_reg, di_s2_reg;
  logic [2:0] c_cnt_reg;
  logic [2:0] u_cnt_reg;
  logic [1:0] di_cnt_reg;
  logic done_reg, gsr_rel_reg, io_rel_reg, err_reg;

  assign sel.clk_sel = startup_clock_select_in;
  assign sel.sync = sync_to_done_input_in;
  assign sel.done_ev = completion_assert_event_in;
  assign sel.gsr_ev = global_reset_release_event_in;
  assign sel.io_ev = io_release_event_in;

  pcs_sel_check u_check (
    .sel(sel)
  );

  // Configuration clock source and edges
  wire cclk_now = cclk_is_output_in ? cclk_reg : cclk_pin_in;
  wire cclk_rise = cclk_now && !cclk_prev_reg;
  wire user_rise = user_s2_reg && !user_prev_reg;
  wire start_rise = (startup_clock_select_in == PCS_CLK_USER) ? user_rise : cclk_rise;
  // Completion alignment meets the length count one bit before the target
  wire [23:0] lc_goal = (length_count_alignment_in == PCS_ALIGN_DONE) ?
    24'(length_count_target_in - 24'h1) : length_count_target_in;
  wire lc_met = (state_reg == PCS_ST_LOAD) && (bits_reg >= lc_goal) && cclk_rise;
  wire running = (state_reg == PCS_ST_RUN);
  wire sel_ok = sel.done_ok && sel.gsr_ok && sel.io_ok;

  // Event hit for a given code
  function automatic logic pcs_hit(input pcs_event_t e, input logic [2:0] c,
    input logic [2:0] u, input logic di, input logic [1:0] dn);
    logic r;
    r = 1'b0;
    case (e)
      PCS_EV_C1: r = (c >= 3'h1);
      PCS_EV_C2: r = (c >= 3'h2);
      PCS_EV_C3: r = (c >= 3'h3);
      PCS_EV_C4: r = (c >= 3'h4);
      PCS_EV_U2: r = (u >= 3'h2);
      PCS_EV_U3: r = (u >= 3'h3);
      PCS_EV_U4: r = (u >= 3'h4);
      PCS_EV_DI: r = di;
      PCS_EV_DI1: r = (dn >= 2'h1);
      PCS_EV_DI2: r = (dn >= 2'h2);
      default: r = 1'b0;
    endcase
    return r;
  endfunction : pcs_hit

  wire done_hit = pcs_hit(completion_assert_event_in, c_cnt_reg, u_cnt_reg, di_s2_reg,
    di_cnt_reg);
  // With sync, releases also wait for done input high
  wire sync_gate = !sync_to_done_input_in || di_s2_reg;
  wire gsr_hit = sync_gate && pcs_hit(global_reset_release_event_in, c_cnt_reg, u_cnt_reg,
    di_s2_reg, di_cnt_reg);
  wire io_hit = sync_gate && pcs_hit(io_release_event_in, c_cnt_reg, u_cnt_reg, di_s2_reg,
    di_cnt_reg);
  wire all_done = done_reg && gsr_rel_reg && io_rel_reg;

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      PCS_ST_LOAD: if (lc_met && sel_ok) state_next = PCS_ST_RUN;
      PCS_ST_RUN: if (all_done) state_next = PCS_ST_END;
      default: state_next = state_reg;
    endcase
  end

  // Internal oscillator divider
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in) osc_reg <= 2'h0;
    else osc_reg <= (osc_reg == PCS_CFG_DIV_LAST) ? 2'h0 : 2'(osc_reg + 2'h1);
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in) cclk_reg <= 1'b0;
    else if (osc_reg == PCS_CFG_DIV_LAST) cclk_reg <= !cclk_reg;
  end

  // Edge detect and done input synchroniser
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      cclk_prev_reg <= 1'b0;
      user_s1_reg <= 1'b0;
      user_s2_reg <= 1'b0;
      user_prev_reg <= 1'b0;
      di_s1_reg <= 1'b0;
      di_s2_reg <= 1'b0;
    end
    else
    begin
      cclk_prev_reg <= cclk_now;
      user_s1_reg <= user_clk_in;
      user_s2_reg <= user_s1_reg;
      user_prev_reg <= user_s2_reg;
      di_s1_reg <= done_input_signal_in;
      di_s2_reg <= di_s1_reg;
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in) bits_reg <= 24'h0;
    else if (state_reg == PCS_ST_LOAD && config_bit_strobe_in && bits_reg != 24'hFFFFFF)
      bits_reg <= 24'(bits_reg + 24'h1);
  end

  // Config edges, with the length count edge as edge one
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in) c_cnt_reg <= 3'h0;
    else if (lc_met && sel_ok) c_cnt_reg <= 3'h1;
    else if (running && cclk_rise && c_cnt_reg < PCS_CNT_W_MAX)
      c_cnt_reg <= 3'(c_cnt_reg + 3'h1);
  end

  // User edges counted after config edge one
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in) u_cnt_reg <= 3'h0;
    else if (running && user_rise && u_cnt_reg < PCS_CNT_W_MAX)
      u_cnt_reg <= (u_cnt_reg == 3'h0) ? 3'h2 : 3'(u_cnt_reg + 3'h1);
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in) di_cnt_reg <= 2'h0;
    else if (running && di_s2_reg && start_rise && di_cnt_reg < PCS_DI_MAX)
      di_cnt_reg <= 2'(di_cnt_reg + 2'h1);
  end

  // Releases are sticky until reset
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      done_reg <= 1'b0;
      gsr_rel_reg <= 1'b0;
      io_rel_reg <= 1'b0;
    end
    else if (running)
    begin
      done_reg <= done_reg || done_hit;
      gsr_rel_reg <= gsr_rel_reg || gsr_hit;
      io_rel_reg <= io_rel_reg || io_hit;
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in) err_reg <= 1'b0;
    else if (state_reg == PCS_ST_LOAD) err_reg <= !sel_ok;
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in) state_reg <= PCS_ST_LOAD;
    else state_reg <= state_next;
  end

  assign cclk_pin_out = cclk_reg;
  assign cclk_pin_oe_out = cclk_is_output_in;
  assign completion_out = done_reg;
  assign global_set_reset_out = !gsr_rel_reg;
  assign io_tristate_out = !io_rel_reg;
  assign selection_error_out = err_reg;
  assign startup_finished_out = (state_reg == PCS_ST_END);

  a_release_sticky: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    $rose(io_rel_reg) |=> io_rel_reg[*8])
    else $error("io release dropped");
  a_gsr_sticky: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    !global_set_reset_out |=> !global_set_reset_out)
    else $error("global reset reasserted");
  a_done_needs_run: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    $rose(done_reg) |-> $past(running) && $past(c_cnt_reg) >= 3'h1)
    else $error("completion before length count");
  a_sync_waits_di: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    $rose(io_rel_reg) && sync_to_done_input_in |-> $past(di_s2_reg))
    else $error("io released before done input");
  a_gsr_sync_wait: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    $rose(gsr_rel_reg) && sync_to_done_input_in |-> $past(di_s2_reg))
    else $error("reset released before done input");
  a_plus_two_edges: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    $rose(di_cnt_reg == 2'h2) |-> $past(start_rise) && $past(di_s2_reg))
    else $error("plus count without startup edge");
  a_user_after_c1: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    $rose(u_cnt_reg != 3'h0) |-> $past(c_cnt_reg) >= 3'h1 && u_cnt_reg == 3'h2)
    else $error("user edge count wrong");
  a_bad_select_hold: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    state_reg == PCS_ST_LOAD && !sel_ok |=> state_reg == PCS_ST_LOAD)
    else $error("startup left load on bad selection");
  a_osc_drive: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    cclk_is_output_in && osc_reg == PCS_CFG_DIV_LAST |=> cclk_pin_out != $past(cclk_pin_out))
    else $error("oscillator did not toggle");

  c_finished: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    $rose(startup_finished_out));
  c_user_clock: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    startup_clock_select_in == PCS_CLK_USER && $rose(done_reg));
  c_sync_release: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    sync_to_done_input_in && $rose(io_rel_reg));
  c_bad_select: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    $rose(selection_error_out));
endmodule : pcs_startup_seq

// *** sim/pcs_partner.sv ***
`timescale 1ns/10ps
module pcs_partner
(
  // Controls from bench
  input wire logic user_clk_en_in,
  input wire logic done_raise_in,
  // Far side signals
  output logic user_clk_out,
  output logic done_line_out
);
  initial user_clk_out = 1'b0;
  // User clock, 40 ns period, stands low when not enabled
  always
  begin
    #20;
    user_clk_out = user_clk_en_in ? ~user_clk_out : 1'b0;
  end
  // Other devices release the shared done line when finished
  assign done_line_out = done_raise_in;
endmodule : pcs_partner

// *** sim/post_config_startup_sequencer_tb_top.sv ***
`timescale 1ns/10ps
module post_config_startup_sequencer_tb_top;
  import pcs_pkg::*;
  localparam int LIMIT = 20000;
  logic ref_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [23:0] target = 24'h000004;
  logic strobe = 1'b0;
  pcs_align_t align = PCS_ALIGN_LENGTH;
  pcs_clk_sel_t clk_sel = PCS_CLK_CONFIG;
  logic sync = 1'b0;
  pcs_event_t done_ev = PCS_DONE_DEFAULT;
  pcs_event_t gsr_ev = PCS_GSR_DEFAULT;
  pcs_event_t io_ev = PCS_IO_DEFAULT;
  logic uclk_en = 1'b0;
  logic done_raise = 1'b0;
  logic cclk_mode = 1'b1;
  logic ext_cclk = 1'b0;
  logic user_clk, done_line, cclk_out, cclk_oe, completion, global_set_reset, tri_st, sel_err, finished;
  int err_count = 0;
  int compares = 0;
  int cyc = 0;
  int t0, tc, ti, tg;

  always #2.5 ref_clk_in = ~ref_clk_in;

  // External config clock, period of eight cycles, low while the pin is an output
  always @(negedge ref_clk_in) ext_cclk <= !cclk_mode && cyc[2];

  pcs_partner partner (.user_clk_en_in(uclk_en), .done_raise_in(done_raise),
    .user_clk_out(user_clk), .done_line_out(done_line));

  pcs_startup_seq dut (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .length_count_target_in(target), .config_bit_strobe_in(strobe),
    .cclk_is_output_in(cclk_mode), .cclk_pin_in(ext_cclk), .length_count_alignment_in(align),
    .startup_clock_select_in(clk_sel), .sync_to_done_input_in(sync),
    .completion_assert_event_in(done_ev), .global_reset_release_event_in(gsr_ev),
    .io_release_event_in(io_ev), .user_clk_in(user_clk), .done_input_signal_in(done_line),
    .cclk_pin_out(cclk_out), .cclk_pin_oe_out(cclk_oe), .completion_out(completion),
    .global_set_reset_out(global_set_reset), .io_tristate_out(tri_st),
    .selection_error_out(sel_err), .startup_finished_out(finished));

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up

  always @(posedge ref_clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      err_count++;
      wrap_up();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  // Reset, apply selections, load bits, record event cycles
  task automatic run_seq(input pcs_clk_sel_t c, input logic s, input pcs_event_t d,
      input pcs_event_t g, input pcs_event_t i, input pcs_align_t a, input int n,
      input int di_at);
    @(negedge ref_clk_in);
    rst_n_in = 1'b0;
    clk_sel = c;
    sync = s;
    done_ev = d;
    gsr_ev = g;
    io_ev = i;
    align = a;
    uclk_en = 1'b0;
    done_raise = 1'b0;
    repeat (10) @(negedge ref_clk_in);
    rst_n_in = 1'b1;
    uclk_en = (c == PCS_CLK_USER);
    strobe = 1'b1;
    repeat (n) @(negedge ref_clk_in);
    strobe = 1'b0;
    t0 = cyc;
    tc = -1;
    ti = -1;
    tg = -1;
    repeat (400)
    begin
      @(negedge ref_clk_in);
      if (di_at >= 0 && cyc - t0 == di_at)
        done_raise = 1'b1;
      if (tc < 0 && completion === 1'b1)
        tc = cyc;
      if (ti < 0 && tri_st === 1'b0)
        ti = cyc;
      if (tg < 0 && global_set_reset === 1'b0)
        tg = cyc;
      if (finished === 1'b1 && tc >= 0 && ti >= 0 && tg >= 0)
        break;
    end
  endtask : run_seq

  task automatic test_defaults();
    logic v;
    run_seq(PCS_CLK_CONFIG, 1'b0, PCS_EV_C1, PCS_EV_C3, PCS_EV_C2, PCS_ALIGN_LENGTH, 4, -1);
    check("cclk_oe", cclk_oe, 1'b1);
    check("sel_ok", sel_err, 1'b0);
    check("io_after_done", ti - tc, 8);
    check("gsr_after_io", tg - ti, 8);
    check("finished", finished, 1'b1);
    check("done_held", completion, 1'b1);
    v = cclk_out;
    repeat (PCS_CFG_DIV) @(negedge ref_clk_in);
    check("cclk_toggle", cclk_out, !v);
    $display("test_defaults finished");
  endtask : test_defaults

  task automatic test_late_edges();
    run_seq(PCS_CLK_CONFIG, 1'b0, PCS_EV_C2, PCS_EV_C4, PCS_EV_C3, PCS_ALIGN_LENGTH, 4, -1);
    check("io_c3_after_c2", ti - tc, 8);
    check("gsr_c4_after_c3", tg - ti, 8);
    $display("test_late_edges finished");
  endtask : test_late_edges

  // Config clock taken from the pin instead of the oscillator
  task automatic test_ext_cclk();
    cclk_mode = 1'b0;
    run_seq(PCS_CLK_CONFIG, 1'b0, PCS_EV_C1, PCS_EV_C3, PCS_EV_C2, PCS_ALIGN_LENGTH, 4, -1);
    check("cclk_oe_input", cclk_oe, 1'b0);
    check("io_after_done_pin", ti - tc, 8);
    check("gsr_after_io_pin", tg - ti, 8);
    cclk_mode = 1'b1;
    $display("test_ext_cclk finished");
  endtask : test_ext_cclk

  task automatic test_invalid();
    run_seq(PCS_CLK_CONFIG, 1'b1, PCS_EV_C4, PCS_EV_C2, PCS_EV_C2, PCS_ALIGN_LENGTH, 4, -1);
    check("sel_error", sel_err, 1'b1);
    check("no_done", completion, 1'b0);
    run_seq(PCS_CLK_USER, 1'b0, PCS_EV_U2, PCS_EV_DI, PCS_EV_U3, PCS_ALIGN_LENGTH, 4, -1);
    check("sel_error_gsr", sel_err, 1'b1);
    check("gsr_held", global_set_reset, 1'b1);
    $display("test_invalid finished");
  endtask : test_invalid

  task automatic test_cclk_sync();
    run_seq(PCS_CLK_CONFIG, 1'b1, PCS_EV_C1, PCS_EV_DI1, PCS_EV_DI, PCS_ALIGN_LENGTH, 4, 60);
    check("done_before_di", tc >= 0 && tc < t0 + 60, 1'b1);
    check("io_on_di", (ti - t0 - 60) inside {[2:5]}, 1'b1);
    check("gsr_di_plus_one", (tg - ti) inside {[1:10]}, 1'b1);
    $display("test_cclk_sync finished");
  endtask : test_cclk_sync

  task automatic test_user_nosync();
    target = 24'h000004;
    run_seq(PCS_CLK_USER, 1'b0, PCS_EV_U2, PCS_EV_U4, PCS_EV_U3, PCS_ALIGN_DONE, 3, -1);
    check("finished_early_goal", finished, 1'b1);
    check("io_u3_after_u2", ti - tc, 8);
    check("gsr_u4_after_u3", tg - ti, 8);
    $display("test_user_nosync finished");
  endtask : test_user_nosync

  task automatic test_user_sync();
    run_seq(PCS_CLK_USER, 1'b1, PCS_EV_U2, PCS_EV_DI2, PCS_EV_DI1, PCS_ALIGN_LENGTH, 4, 100);
    check("io_waits_di", ti > t0 + 100, 1'b1);
    check("gsr_one_user_edge", tg - ti, 8);
    check("finished_user", finished, 1'b1);
    $display("test_user_sync finished");
  endtask : test_user_sync

  initial
  begin
    repeat (10) @(negedge ref_clk_in);
    test_defaults();
    test_late_edges();
    test_ext_cclk();
    test_invalid();
    test_cclk_sync();
    test_user_nosync();
    test_user_sync();
    wrap_up();
  end
endmodule : post_config_startup_sequencer_tb_top
